// ==== cexfp_core.sv ====
// Exception entry/return unit with SP-load replay, lazy FP stacking and late vector select
// Function
// - SP load interrupted in data phase replays once
// - Replay covers five SP load addressing forms
// - Writeback forms advance base on every execution
// - Divide and square root take fourteen cycles
// - Accepted interrupt never aborts running divide
// - Lazy mode defers FP stacking to first FP instruction
// - Lazy stacking enabled after reset
// - Handler starts at least twelve cycles after acceptance
// - Early return under lazy mode loses low-bank result
// - Clearing bit 30 disables lazy stacking
// - Stack wait states avoid the lost result
// - Stores buffer while execution continues
// - Late reselection can make vector differ from acknowledge
// - Mismatch needs buffered store accepted two cycles late
module cexfp_core (
  input wire logic MCLK, // Core clock
  input wire logic RST_N, // Async reset, active low
  input wire logic WB_CYC_I, // Wishbone cycle
  input wire logic WB_STB_I, // Wishbone strobe
  input wire logic WB_WE_I, // Wishbone write
  input wire logic [31:0] WB_ADR_I, // Wishbone byte address
  input wire logic [3:0] WB_SEL_I, // Wishbone byte lanes
  input wire logic [31:0] WB_DAT_I, // Wishbone write data
  output logic [31:0] WB_DAT_O, // Wishbone read data
  output logic WB_ACK_O, // Wishbone acknowledge
  input wire logic IRQ_REQ, // Interrupt pending from controller
  input wire logic [7:0] IRQ_ID, // Currently selected interrupt
  input wire logic STK_WAIT, // Wait state on stack access this cycle
  input wire logic HND_FP_INSN, // Handler executes an FP instruction
  input wire logic EXC_RET, // Branch-exchange return executed
  output logic IRQ_ACK, // Interrupt acknowledge pulse
  output logic [7:0] IRQ_ACK_ID, // Acknowledged interrupt
  output logic VEC_FETCH, // Vector fetch pulse
  output logic [7:0] VEC_ID, // Vector fetched
  output logic HND_START, // First handler instruction starts
  output logic FP_CTX_SAVE, // FP context stacked
  input wire logic LDSP_ISSUE, // SP load issued
  input wire logic [2:0] LDSP_FORM, // Addressing form
  input wire logic [31:0] LDSP_BASE, // Base register value
  input wire logic [31:0] LDSP_OPND, // Immediate or index
  input wire logic LDSP_DATA_OK, // Load data returned
  input wire logic [31:0] LDSP_DATA, // Load data
  output logic LDSP_REQ, // Load address phase
  output logic [31:0] LDSP_ADDR, // Load address
  output logic BASE_WB_EN, // Base writeback pulse
  output logic [31:0] BASE_WB, // New base value
  output logic SP_WR_EN, // Stack pointer written
  output logic [31:0] SP_VALUE, // Value written to SP
  input wire logic FP_ISSUE, // Divide or square root issued
  input wire logic [4:0] FP_DEST, // Destination register
  input wire logic [31:0] FP_RES, // Operation result
  input wire logic [3:0] FP_FLAGS, // Status flags of result
  output logic FP_WR_EN, // Register bank write
  output logic [4:0] FP_WR_REG, // Register written
  output logic [31:0] FP_WR_DATA, // Data written
  output logic FP_RESULT_LOST, // Result dropped pulse
  input wire logic ST_ISSUE, // Buffered immediate store issued
  input wire logic ST_ACCEPT, // Bus accepts store data
  output logic WBUF_BUSY // Write buffer occupied
);
  cexfp_div_if dif ();

  cexfp_fpdiv u_div (
    .clk(MCLK),
    .rst_n(RST_N),
    .dv(dif.unit)
  );

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  logic [31:0] fpcc;
  logic fpu_en;
  logic [3:0] fp_status;
  cexfp_pkg::cexfp_exc_t ex_state;
  cexfp_pkg::cexfp_exc_t next_ex_state;
  logic replay_pend;
  logic lazy_pend;
  logic doom;

  wire wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  wire wb_wr = wb_req && WB_WE_I;
  wire hit_fpcc = WB_ADR_I == cexfp_pkg::FPCC_ADDR;
  wire hit_ctrl = WB_ADR_I == cexfp_pkg::CTRL_ADDR;
  wire hit_stat = WB_ADR_I == cexfp_pkg::STAT_ADDR;
  wire lazy = fpcc[cexfp_pkg::LAZY_EN_BIT];
  wire [31:0] stat = {20'h0_0000, fp_status, 2'h0, doom, dif.busy, WBUF_BUSY, replay_pend, ex_state};
  wire [31:0] rd_data = hit_fpcc ? fpcc : hit_ctrl ? {31'h0, fpu_en} : hit_stat ? stat : 32'h0000_0000;
  logic [31:0] next_fpcc;

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_lane
      assign next_fpcc[8*g +: 8] = (wb_wr && hit_fpcc && WB_SEL_I[g]) ? WB_DAT_I[8*g +: 8] : fpcc[8*g +: 8];
    end
  endgenerate

  // Unmapped addresses still ack and read zero so a stray access never hangs the bus
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
      fpcc <= cexfp_pkg::FPCC_RESET;
      fpu_en <= cexfp_pkg::CTRL_FPU_EN_RESET;
    end
    else
    begin
      WB_ACK_O <= wb_req;
      WB_DAT_O <= wb_req ? rd_data : WB_DAT_O;
      fpcc <= next_fpcc;
      fpu_en <= (wb_wr && hit_ctrl && WB_SEL_I[0]) ? WB_DAT_I[0] : fpu_en;
    end
  end

  // ----------------------------------------
  // Exception sequencer
  // ----------------------------------------
  logic [3:0] stk_cnt;
  logic [1:0] ret_cnt;

  wire accept = ex_state == cexfp_pkg::EX_IDLE && IRQ_REQ;
  wire stk_done = ex_state == cexfp_pkg::EX_STACK && !STK_WAIT && stk_cnt == cexfp_pkg::STACK_CYCLES - 4'h1;
  wire ret = ex_state == cexfp_pkg::EX_HANDLER && EXC_RET;
  wire tail = ret && IRQ_REQ;
  wire tail_now = tail && !WBUF_BUSY;
  wire vw_done = ex_state == cexfp_pkg::EX_VECWAIT && ST_ACCEPT;
  wire late = ret_cnt >= cexfp_pkg::VEC_LATE_CYCLES;
  wire hstart = stk_done || tail_now || vw_done;
  wire replay_go = ret && !IRQ_REQ && replay_pend;

  always_comb
  begin
    next_ex_state = ex_state;
    case (ex_state)
      cexfp_pkg::EX_IDLE:
        next_ex_state = IRQ_REQ ? cexfp_pkg::EX_STACK : cexfp_pkg::EX_IDLE;
      cexfp_pkg::EX_STACK:
        next_ex_state = stk_done ? cexfp_pkg::EX_HANDLER : cexfp_pkg::EX_STACK;
      cexfp_pkg::EX_HANDLER:
        if (ret)
        begin
          next_ex_state = !IRQ_REQ ? cexfp_pkg::EX_IDLE : WBUF_BUSY ? cexfp_pkg::EX_VECWAIT : cexfp_pkg::EX_HANDLER;
        end
      cexfp_pkg::EX_VECWAIT:
        next_ex_state = ST_ACCEPT ? cexfp_pkg::EX_HANDLER : cexfp_pkg::EX_VECWAIT;
      default:
        next_ex_state = cexfp_pkg::EX_IDLE;
    endcase
  end

  // Wait states freeze the stacking count, so slow stack memory lengthens entry
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ex_state <= cexfp_pkg::EX_IDLE;
      stk_cnt <= 4'h0;
      ret_cnt <= 2'h0;
    end
    else
    begin
      ex_state <= next_ex_state;
      stk_cnt <= accept ? 4'h0 : (ex_state == cexfp_pkg::EX_STACK && !STK_WAIT) ? stk_cnt + 4'h1 : stk_cnt;
      ret_cnt <= ret ? 2'h1 : (ret_cnt != 2'h3) ? ret_cnt + 2'h1 : ret_cnt;
    end
  end

  // Tail-chain acknowledge is taken at the return, but the vector is read when the
  // buffered store drains; a reselection in between yields a different vector if the drain comes two or more cycles after the return
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      IRQ_ACK <= 1'b0;
      IRQ_ACK_ID <= 8'h00;
      VEC_FETCH <= 1'b0;
      VEC_ID <= 8'h00;
      HND_START <= 1'b0;
      WBUF_BUSY <= 1'b0;
    end
    else
    begin
      IRQ_ACK <= accept || tail;
      IRQ_ACK_ID <= (accept || tail) ? IRQ_ID : IRQ_ACK_ID;
      VEC_FETCH <= hstart;
      VEC_ID <= stk_done ? IRQ_ACK_ID : tail_now ? IRQ_ID : (vw_done && late) ? IRQ_ID : vw_done ? IRQ_ACK_ID : VEC_ID;
      HND_START <= hstart;
      WBUF_BUSY <= ST_ISSUE || (WBUF_BUSY && !ST_ACCEPT);
    end
  end

  // ----------------------------------------
  // Lazy FP context
  // ----------------------------------------
  wire save_now = (accept && fpu_en && !lazy) || (ex_state == cexfp_pkg::EX_HANDLER && HND_FP_INSN && lazy_pend);

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      FP_CTX_SAVE <= 1'b0;
      lazy_pend <= 1'b0;
    end
    else
    begin
      FP_CTX_SAVE <= save_now;
      lazy_pend <= accept ? (fpu_en && lazy) : (save_now || (ret && !IRQ_REQ)) ? 1'b0 : lazy_pend;
    end
  end

  // ----------------------------------------
  // SP load and replay
  // ----------------------------------------
  logic ld_go;
  logic ld_phase;
  logic ld_replay;
  cexfp_pkg::cexfp_form_t ld_form;
  logic [31:0] ld_base;
  logic [31:0] ld_opnd;
  logic [31:0] first_addr;

  wire [31:0] ld_sum = ld_base + ld_opnd;
  wire addr_is_base = ld_form == cexfp_pkg::FORM_POST || ld_form == cexfp_pkg::FORM_REG;
  wire wb_form = ld_form == cexfp_pkg::FORM_POST || ld_form == cexfp_pkg::FORM_PRE_WB;
  wire [31:0] ld_addr = addr_is_base ? ld_base : ld_sum;
  wire ld_take = LDSP_ISSUE && !ld_go && !ld_phase && !replay_pend;

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ld_go <= 1'b0;
      ld_phase <= 1'b0;
      ld_replay <= 1'b0;
      ld_form <= cexfp_pkg::FORM_REG;
      ld_base <= 32'h0000_0000;
      ld_opnd <= 32'h0000_0000;
      first_addr <= 32'h0000_0000;
      replay_pend <= 1'b0;
    end
    else
    begin
      ld_go <= ld_take || replay_go;
      ld_replay <= ld_take ? 1'b0 : replay_go ? 1'b1 : ld_replay;
      ld_form <= ld_take ? cexfp_pkg::cexfp_form_t'(LDSP_FORM) : ld_form;
      ld_opnd <= ld_take ? LDSP_OPND : ld_opnd;
      // Writeback-form base advances on each execution, so a replay reads from the moved base
      ld_base <= ld_take ? LDSP_BASE : (ld_go && wb_form) ? ld_sum : ld_base;
      first_addr <= (ld_go && !ld_replay) ? ld_addr : first_addr;
      ld_phase <= ld_go || (ld_phase && !LDSP_DATA_OK);
      replay_pend <= (accept && ld_phase) || (replay_pend && !replay_go);
    end
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      LDSP_REQ <= 1'b0;
      LDSP_ADDR <= 32'h0000_0000;
      BASE_WB_EN <= 1'b0;
      BASE_WB <= 32'h0000_0000;
      SP_WR_EN <= 1'b0;
      SP_VALUE <= 32'h0000_0000;
    end
    else
    begin
      LDSP_REQ <= ld_go;
      LDSP_ADDR <= ld_go ? ld_addr : LDSP_ADDR;
      BASE_WB_EN <= ld_go && wb_form;
      BASE_WB <= ld_go ? ld_sum : BASE_WB;
      SP_WR_EN <= ld_phase && LDSP_DATA_OK;
      SP_VALUE <= (ld_phase && LDSP_DATA_OK) ? LDSP_DATA : SP_VALUE;
    end
  end

  // ----------------------------------------
  // FP divide completion
  // ----------------------------------------
  assign dif.issue = FP_ISSUE;
  assign dif.issue_dest = FP_DEST;
  assign dif.issue_res = FP_RES;
  assign dif.issue_flags = FP_FLAGS;

  // Only a return while the divide is still running can drop it; long stacking
  // with wait states lets the divide finish first
  wire doom_set = ret && dif.busy && fpu_en && lazy_pend && dif.dest < cexfp_pkg::LOW_BANK_LIMIT;

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      doom <= 1'b0;
      FP_WR_EN <= 1'b0;
      FP_WR_REG <= 5'h00;
      FP_WR_DATA <= 32'h0000_0000;
      FP_RESULT_LOST <= 1'b0;
      fp_status <= 4'h0;
    end
    else
    begin
      doom <= doom_set || (doom && !dif.done);
      FP_WR_EN <= dif.done && !doom;
      FP_RESULT_LOST <= dif.done && doom;
      FP_WR_REG <= dif.done ? dif.dest : FP_WR_REG;
      FP_WR_DATA <= (dif.done && !doom) ? dif.res : FP_WR_DATA;
      fp_status <= (dif.done && !doom) ? dif.flags : fp_status;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [4:0] since_acc;

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      since_acc <= 5'h00;
    end
    else
    begin
      since_acc <= accept ? 5'h00 : (since_acc != 5'h1F) ? since_acc + 5'h01 : since_acc;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  a_entry_min_time: assert property (stk_done |-> since_acc >= {1'b0, cexfp_pkg::STACK_CYCLES - 4'h1})
    else $error("handler started too early");
  a_replay_issue: assert property (replay_go |-> ##2 LDSP_REQ) else $error("replay not issued");
  a_wb_forms: assert property (LDSP_REQ |-> BASE_WB_EN == $past(wb_form)) else $error("base writeback form wrong");
  a_replay_same: assert property (LDSP_REQ && $past(ld_replay) && !BASE_WB_EN |-> LDSP_ADDR == first_addr)
    else $error("replay address moved");
  a_div_survives: assert property (accept && dif.busy |-> ##[1:14] dif.done) else $error("divide aborted");
  a_lazy_defer: assert property (accept && fpu_en && lazy |=> !FP_CTX_SAVE) else $error("FP context stacked eagerly");
  a_lazy_clear: assert property (wb_wr && hit_fpcc && WB_SEL_I[3] && !WB_DAT_I[30] |=> !lazy)
    else $error("lazy bit not cleared");
  a_result_lost: assert property (doom_set |-> ##[1:14] FP_RESULT_LOST) else $error("doomed result written");
  a_vec_mismatch: assert property (VEC_FETCH && VEC_ID != IRQ_ACK_ID |-> $past(vw_done && late))
    else $error("vector mismatch without late store");
  a_wbuf_hold: assert property (WBUF_BUSY && !ST_ACCEPT |=> WBUF_BUSY) else $error("write buffer dropped store");

  c_replay: cover property (replay_go ##2 LDSP_REQ);
  c_lost: cover property (FP_RESULT_LOST);
  c_mismatch: cover property (VEC_FETCH && VEC_ID != IRQ_ACK_ID);
  c_lazy_save: cover property (FP_CTX_SAVE && ex_state == cexfp_pkg::EX_HANDLER);
endmodule

// ==== cexfp_pkg.sv ====
// Shared constants and types for the exception and FP-stacking unit
package cexfp_pkg;
  localparam logic [31:0] FPCC_ADDR = 32'hE000_EF34;
  localparam logic [31:0] CTRL_ADDR = 32'hE000_EF38;
  localparam logic [31:0] STAT_ADDR = 32'hE000_EF3C;
  localparam int LAZY_EN_BIT = 30;
  localparam logic [31:0] FPCC_RESET = 32'h4000_0000;
  localparam logic CTRL_FPU_EN_RESET = 1'b0;
  localparam logic [3:0] FPDIV_CYCLES = 4'hE;
  localparam logic [3:0] STACK_CYCLES = 4'hC;
  localparam logic [1:0] VEC_LATE_CYCLES = 2'h2;
  localparam logic [4:0] LOW_BANK_LIMIT = 5'h10;
  typedef enum logic [2:0] {
    FORM_POST,
    FORM_PRE_WB,
    FORM_OFFS,
    FORM_REG,
    FORM_REGREG
  } cexfp_form_t;
  typedef enum logic [1:0] {
    EX_IDLE,
    EX_STACK,
    EX_HANDLER,
    EX_VECWAIT
  } cexfp_exc_t;
endpackage

// ==== cexfp_div_if.sv ====
// Carrier between the exception core and the FP divide/square-root unit
interface cexfp_div_if;
  logic issue;
  logic [4:0] issue_dest;
  logic [31:0] issue_res;
  logic [3:0] issue_flags;
  logic busy;
  logic done;
  logic [4:0] dest;
  logic [31:0] res;
  logic [3:0] flags;
  modport unit (input issue, issue_dest, issue_res, issue_flags, output busy, done, dest, res, flags);
  modport core (output issue, issue_dest, issue_res, issue_flags, input busy, done, dest, res, flags);
endinterface

// ==== cexfp_fpdiv.sv ====
// Fixed-latency FP divide / square-root sequencer
module cexfp_fpdiv (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Async reset, active low
  cexfp_div_if.unit dv // Issue and completion
);
  logic [3:0] cnt;

  // No abort input exists: an accepted interrupt cannot cut an operation short
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 4'h0;
      dv.busy <= 1'b0;
      dv.done <= 1'b0;
      dv.dest <= 5'h00;
      dv.res <= 32'h0000_0000;
      dv.flags <= 4'h0;
    end
    else if (dv.issue && !dv.busy)
    begin
      cnt <= cexfp_pkg::FPDIV_CYCLES - 4'h2;
      dv.busy <= 1'b1;
      dv.done <= 1'b0;
      dv.dest <= dv.issue_dest;
      dv.res <= dv.issue_res;
      dv.flags <= dv.issue_flags;
    end
    else
    begin
      dv.done <= dv.busy && cnt == 4'h0;
      dv.busy <= dv.busy && cnt != 4'h0;
      cnt <= (cnt != 4'h0) ? cnt - 4'h1 : cnt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_div_latency: assert property (dv.issue && !dv.busy |-> ##14 dv.done) else $error("divide not done after 14 cycles");
  a_div_busy_span: assert property (dv.issue && !dv.busy |=> dv.busy [*8]) else $error("divide busy dropped early");
endmodule

// ==== cexfp_partner.sv ====
// Far-side model: interrupt controller, stack memory, load bus and store bus
module cexfp_partner #(
  parameter int LD_LAT = 20, // Load data latency in cycles
  parameter int ST_LAT = 6 // Store data wait states
) (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Async reset, active low
  input wire logic pend, // Bench raises a request
  input wire logic [7:0] sel_id, // Bench choice of next interrupt
  input wire logic [1:0] wait_n, // Stack wait states per entry
  input wire logic irq_ack, // Acknowledge from core
  input wire logic ld_req, // Load address phase
  input wire logic [31:0] ld_addr, // Load address
  input wire logic wbuf_busy, // Store held in core buffer
  output logic irq_req, // Pending request
  output logic [7:0] irq_id, // Selected interrupt
  output logic stk_wait, // Stack wait state
  output logic ld_ok, // Load data valid
  output logic [31:0] ld_data, // Load data
  output logic st_accept // Store data accepted
);
  int ld_cnt;
  int st_cnt;
  logic [1:0] wcnt;
  logic [31:0] ld_a;

  // Waits come as one unbroken run right after the acknowledge, not one per access
  assign stk_wait = wcnt != 2'h0;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {irq_req, irq_id, wcnt, ld_a, ld_ok, ld_data, st_accept} <= '0;
      ld_cnt <= 0;
      st_cnt <= 0;
    end
    else
    begin
      // Request stays up until the core acknowledges it
      irq_req <= pend | (irq_req & ~irq_ack);
      irq_id <= sel_id;
      wcnt <= irq_ack ? wait_n : wcnt - 2'(wcnt != 2'h0);
      ld_cnt <= ld_req ? LD_LAT : ld_cnt - int'(ld_cnt != 0);
      ld_a <= ld_req ? ld_addr : ld_a;
      ld_ok <= ld_cnt == 1;
      // Outside the data beat the bus toggles, so a stale copy is never mistaken for data
      ld_data <= (ld_cnt == 1) ? ~ld_a : ~ld_data;
      st_cnt <= wbuf_busy ? st_cnt + 1 : 0;
      st_accept <= wbuf_busy && st_cnt == ST_LAT - 1;
    end
  end
endmodule

// ==== cexfp_tb.sv ====
// Self-checking bench for the exception and FP-stacking unit
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic lazy;
    logic [1:0] w;
    logic fpi;
    logic lost;
    logic save;
  } cexfp_row_t;
  localparam int E_ACK = 0, E_HND = 1, E_SAVE = 2, E_WR = 3, E_LOST = 4, E_LD = 5;
  localparam logic [5:0] P_IRQ = 6'h01, P_RET = 6'h02, P_FPI = 6'h04, P_FP = 6'h08, P_LD = 6'h10, P_ST = 6'h20;
  logic mclk, rst_n, cyc, stb, we, ack, irq_req, stk_wait, irq_ack, vec_fetch, hnd_start, ctx_save;
  logic ld_ok, ld_req, sp_wr_en, fp_wr_en, fp_lost, st_accept, wbuf_busy, base_wb_en;
  logic [1:0] wait_n;
  logic [2:0] ld_form;
  logic [3:0] sel, fp_flags;
  logic [4:0] fp_dest, wr_reg, reg_seen;
  logic [5:0] pl;
  logic [7:0] irq_id, ack_id, vec_id, sel_id, ack_seen, vec_seen;
  logic [31:0] adr, wdat, rdat, ld_base, ld_opnd, ld_data, ld_addr, sp_value, fp_res, fp_wr_data;
  logic [31:0] la_prev, la_last, sp_seen, wr_seen, q, base_wb, bw_seen;
  int failures, n_checks, cyc_n, bw_n, n_wr;
  int cnt [8];
  int tm [8];
  cexfp_row_t rows [4] = '{
    '{1'b1, 2'h0, 1'b0, 1'b1, 1'b0},
    '{1'b1, 2'h2, 1'b0, 1'b0, 1'b0},
    '{1'b1, 2'h0, 1'b1, 1'b0, 1'b1},
    '{1'b0, 2'h0, 1'b0, 1'b0, 1'b1}
  };
  wire pend = pl[0];
  wire exc_ret = pl[1];
  wire fpi = pl[2];
  wire fp_issue = pl[3];
  wire ld_issue = pl[4];
  wire st_issue = pl[5];
  wire [7:0] ev = {vec_fetch, sp_wr_en, ld_req, fp_lost, fp_wr_en, ctx_save, hnd_start, irq_ack};

  cexfp_core dut (
    .MCLK(mclk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .IRQ_REQ(irq_req), .IRQ_ID(irq_id), .STK_WAIT(stk_wait),
    .HND_FP_INSN(fpi), .EXC_RET(exc_ret), .IRQ_ACK(irq_ack), .IRQ_ACK_ID(ack_id), .VEC_FETCH(vec_fetch),
    .VEC_ID(vec_id), .HND_START(hnd_start), .FP_CTX_SAVE(ctx_save), .LDSP_ISSUE(ld_issue), .LDSP_FORM(ld_form),
    .LDSP_BASE(ld_base), .LDSP_OPND(ld_opnd), .LDSP_DATA_OK(ld_ok), .LDSP_DATA(ld_data), .LDSP_REQ(ld_req),
    .LDSP_ADDR(ld_addr), .BASE_WB_EN(base_wb_en), .BASE_WB(base_wb), .SP_WR_EN(sp_wr_en), .SP_VALUE(sp_value),
    .FP_ISSUE(fp_issue), .FP_DEST(fp_dest), .FP_RES(fp_res), .FP_FLAGS(fp_flags), .FP_WR_EN(fp_wr_en),
    .FP_WR_REG(wr_reg),
    .FP_WR_DATA(fp_wr_data), .FP_RESULT_LOST(fp_lost), .ST_ISSUE(st_issue), .ST_ACCEPT(st_accept),
    .WBUF_BUSY(wbuf_busy)
  );

  cexfp_partner partner (
    .clk(mclk), .rst_n(rst_n), .pend(pend), .sel_id(sel_id), .wait_n(wait_n), .irq_ack(irq_ack), .ld_req(ld_req),
    .ld_addr(ld_addr), .wbuf_busy(wbuf_busy), .irq_req(irq_req), .irq_id(irq_id), .stk_wait(stk_wait),
    .ld_ok(ld_ok), .ld_data(ld_data), .st_accept(st_accept)
  );

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ----------------------------------------
  // Event monitor and helpers
  // ----------------------------------------
  // Pulses are counted and time-stamped so checks never depend on catching a single edge
  always @(posedge mclk)
  begin
    cyc_n++;
    for (int i = 0; i < 8; i++)
    begin
      cnt[i] += int'(ev[i] === 1'b1);
      if (ev[i] === 1'b1) tm[i] = cyc_n;
    end
    if (ld_req === 1'b1) {la_prev, la_last} = {la_last, ld_addr};
    if (irq_ack === 1'b1) ack_seen = ack_id;
    if (vec_fetch === 1'b1) vec_seen = vec_id;
    if (sp_wr_en === 1'b1) sp_seen = sp_value;
    if (fp_wr_en === 1'b1) wr_seen = fp_wr_data;
    if (fp_wr_en === 1'b1) reg_seen = wr_reg;
    if (base_wb_en === 1'b1) bw_seen = base_wb;
    bw_n += int'(base_wb_en === 1'b1);
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic pulse(input logic [5:0] m);
    pl <= m;
    tick(1);
    pl <= 6'h00;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    int i;
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hF};
    for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge mclk);
    r = rdat;
    {cyc, stb} <= 2'b00;
    if (ack !== 1'b1)
    begin
      failures++;
      end_sim();
    end
    tick(1);
  endtask

  task automatic fp_case(input cexfp_row_t r);
    int c [8];
    wb(1'b1, cexfp_pkg::FPCC_ADDR, r.lazy ? cexfp_pkg::FPCC_RESET : 32'h0000_0000, q);
    c = cnt;
    wait_n <= r.w;
    pulse(P_IRQ);
    tick(1);
    pulse(P_FP);
    // The FP instruction lands in the handler's first cycle so the return still meets a running divide
    tick(12 + int'(r.w) - int'(r.fpi));
    if (r.fpi)
    begin
      pl <= P_FPI;
      tick(1);
    end
    pulse(P_RET);
    tick(24);
    chk("handler delay", tm[E_HND] - tm[E_ACK], 12 + int'(r.w));
    chk("lost count", cnt[E_LOST] - c[E_LOST], r.lost);
    chk("write count", cnt[E_WR] - c[E_WR], !r.lost);
    chk("save count", cnt[E_SAVE] - c[E_SAVE], r.save);
    chk("finish time", (r.lost ? tm[E_LOST] : tm[E_WR]) - tm[E_ACK], 15);
    if (r.save) chk("save time", tm[E_SAVE], r.lazy ? tm[E_HND] + 1 : tm[E_ACK]);
    if (!r.lost) chk("result", wr_seen, 32'h1234_5678);
    if (!r.lost) chk("result register", {27'h000_0000, reg_seen}, 32'h0000_0003);
  endtask

  task automatic sp_case(input int f);
    int c [8];
    int b0;
    logic [31:0] a1, a2;
    c = cnt;
    b0 = bw_n;
    a1 = (f == 0 || f == 3) ? 32'h2000_0100 : 32'h2000_0110;
    a2 = (f == 0) ? 32'h2000_0110 : (f == 1) ? 32'h2000_0120 : a1;
    ld_form <= 3'(f);
    pulse(P_LD);
    tick(3);
    pulse(P_IRQ);
    tick(40);
    pulse(P_RET);
    tick(40);
    chk("load count", cnt[E_LD] - c[E_LD], 2);
    chk("first address", la_prev, a1);
    chk("replay address", la_last, a2);
    chk("stack pointer", sp_seen, ~a2);
    chk("base writebacks", bw_n - b0, (f < 2) ? 2 : 0);
    if (f < 2) chk("advanced base", bw_seen, 32'h2000_0120);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {pl, wait_n, ld_form, cyc, stb, we, sel, adr, wdat} = '0;
    {sel_id, fp_dest, fp_res, fp_flags} = {8'h21, 5'h03, 32'h1234_5678, 4'h5};
    {ld_base, ld_opnd} = {32'h2000_0100, 32'h0000_0010};
    rst_n = 1'b0;
    tick(4);
    rst_n <= 1'b1;
    tick(1);
    wb(1'b0, cexfp_pkg::FPCC_ADDR, 32'h0000_0000, q);
    chk("context control reset", q, cexfp_pkg::FPCC_RESET);
    wb(1'b0, 32'hE000_EF40, 32'h0000_0000, q);
    chk("unmapped read", q, 32'h0000_0000);
    wb(1'b1, cexfp_pkg::CTRL_ADDR, 32'h0000_0001, q);
    wb(1'b0, cexfp_pkg::CTRL_ADDR, 32'h0000_0000, q);
    chk("fpu enable", q, 32'h0000_0001);
    $display("test registers done");
    foreach (rows[i]) fp_case(rows[i]);
    $display("test divide rows done");
    for (int f = 0; f < 5; f++) sp_case(f);
    $display("test stack pointer loads done");
    sel_id <= 8'h05;
    n_wr = cnt[E_WR];
    // Divide already running when the interrupt is accepted
    pulse(P_IRQ | P_FP);
    tick(20);
    chk("divide across entry", cnt[E_WR] - n_wr, 1);
    sel_id <= 8'h0B;
    pulse(P_ST | P_IRQ);
    tick(1);
    chk("buffer busy", wbuf_busy, 1'b1);
    pulse(P_RET);
    // A higher selection arrives while the store data is still held off
    sel_id <= 8'h0C;
    tick(30);
    chk("acknowledged id", ack_seen, 8'h0B);
    chk("fetched vector", vec_seen, 8'h0C);
    chk("buffer drained", wbuf_busy, 1'b0);
    $display("test late vector done");
    rst_n <= 1'b0;
    tick(4);
    chk("buffer in reset", wbuf_busy, 1'b0);
    rst_n <= 1'b1;
    tick(1);
    wb(1'b0, cexfp_pkg::FPCC_ADDR, 32'h0000_0000, q);
    chk("context control after reset", q, cexfp_pkg::FPCC_RESET);
    $display("test second reset done");
    end_sim();
  end
endmodule
